/* amp_fault_defines.svh */
// Constants for the amplifier stage fault supervisor: register offsets, field positions,
// reset values and timing counts. Assumes a 250 MHz pclk and a 12-bit APB byte address.
// How it works
// [R1] Overcurrent trip limits current before any shutdown
// [R2] Persistent overcurrent latches overload, bridge goes Hi-Z
// [R3] Resistor setting selects the overcurrent trip threshold
// [R4] Warning level pulls warning low, no shutdown
// [R5] Error level: Hi-Z, shutdown low, error latched
// [R6] Only reset clears the latched overtemperature error
// [R7] Power-on reset clears overload; supplies must be good
// [R8] Any low supply: immediate Hi-Z and shutdown low
// [R9] Undervoltage shutdown self-clears when supplies recover
// [R10] Reset pin low forces every output Hi-Z
// [R11] Reset pin low enables weak bootstrap pulldowns
// [R12] Reset pin low erases all stored faults
// [R13] Overload recovery only through reset rising edge
// [R14] Any stuck PWM input shuts device down
// [R15] Stuck PWM shutdown clears on renewed switching
// [R16] Invalid PWM detection reacts with no delay
// [R17] Stuck PWM shutdown pulls shutdown flag low
// [R18] Modulator should limit modulation index to 96.1%
// [R19] Reset pin low holds both flags high
// [R20] Controller waits 1 s before overload reset; the bench drives the pin low 113 cycles after the latch sets
// [R21] Stuck timeout counts clocks, restarts each edge
// [R22] Shutdown flag low for any active cause
`ifndef AMP_FAULT_DEFINES_SVH
`define AMP_FAULT_DEFINES_SVH

// Register byte offsets.
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_TRIP        12'h008

// Control register fields and reset value.
`define CTRL_SEL_LSB    0
`define CTRL_SEL_W      3
`define CTRL_RESET      3'h0

// Status register field positions.
`define ST_OVERLOAD     0
`define ST_OVERTEMP     1
`define ST_UNDERVOLT    2
`define ST_STUCK_LSB    3
`define ST_WARN         5
`define ST_CLIMIT       6
`define ST_HIZ          7
`define ST_SD_PIN       8
`define ST_WARN_PIN     9
`define ST_MODE_LSB     10

// Typical trip current in amperes per resistor setting.
`define AMPS_22K        8'h10
`define AMPS_27K        8'h0d
`define AMPS_47K        8'h08
`define AMPS_68K        8'h05
`define AMPS_100K       8'h04

// Timing: clock period and the two supervision times, in ns.
`define CLK_PERIOD_NS   4
`define STUCK_TIME_NS   10000
`define OVERLOAD_TIME_NS 1000
`define STUCK_CYCLES    ((`STUCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVERLOAD_CYCLES ((`OVERLOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W           12
`define PWM_N           2

`endif

/* amp_fault_pkg.sv */
// Types for the amplifier stage fault supervisor.
// Assumes amp_fault_defines.svh is compiled alongside for the numeric constants.
`default_nettype none
package amp_fault_pkg;

  // Supervisor mode, one-hot.
  typedef enum logic [2:0] {
    MODE_HOLD = 3'b001,
    MODE_RUN  = 3'b010,
    MODE_OFF  = 3'b100
  } mode_t;

  // Trip level resistor setting.
  typedef enum logic [2:0] {
    TRIP_22K  = 3'h0,
    TRIP_27K  = 3'h1,
    TRIP_47K  = 3'h2,
    TRIP_68K  = 3'h3,
    TRIP_100K = 3'h4
  } trip_sel_t;

endpackage
`default_nettype wire

/* amp_stage_fault_supervisor.sv */
// Fault supervisor for a bridge-tied PWM power stage, with an APB register slave.
// Assumes all fault inputs and PWM inputs are synchronous to pclk and that the
// shutdown and warning flags are open-drain pins pulled up outside.
`timescale 1ns/1ps
`include "amp_fault_defines.svh"
`default_nettype none

module amp_stage_fault_supervisor (
  // Clock, reset and clock enable.
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Device reset pin from the controller and supply monitors.
  input  wire logic                dev_reset_n,
  input  wire logic                gate_drive_supply_ok,
  input  wire logic                vdd_supply_ok,
  // Analog detectors.
  input  wire logic                overcurrent_trip,
  input  wire logic                temp_warn_level,
  input  wire logic                temp_error_level,
  // PWM inputs.
  input  wire logic [`PWM_N-1:0]   pwm_in,
  // Power stage control.
  output logic                     bridge_hiz,
  output logic                     current_limit,
  output logic                     weak_pulldown_en,
  output amp_fault_pkg::trip_sel_t trip_level_resistor,
  // Open-drain shutdown flag.
  input  wire logic                shutdown_flag_n_i,
  output logic                     shutdown_flag_n_o,
  output logic                     shutdown_flag_n_oe,
  // Open-drain temperature warning.
  input  wire logic                temp_warning_n_i,
  output logic                     temp_warning_n_o,
  output logic                     temp_warning_n_oe
);
  import amp_fault_pkg::*;

  // Counter limits, cut to the counter width on purpose; both fit in twelve bits.
  localparam logic [`CNT_W-1:0] STUCK_LIM = `CNT_W'(`STUCK_CYCLES);
  localparam logic [`CNT_W-1:0] OL_LIM    = `CNT_W'(`OVERLOAD_CYCLES);

  // Typical trip current for a resistor setting; unknown codes read as the lowest.
  function automatic logic [7:0] trip_amps(input trip_sel_t sel);
    logic [7:0] a;
    a = `AMPS_100K;
    unique case (sel)
      TRIP_22K:  a = `AMPS_22K;
      TRIP_27K:  a = `AMPS_27K;
      TRIP_47K:  a = `AMPS_47K;
      TRIP_68K:  a = `AMPS_68K;
      TRIP_100K: a = `AMPS_100K;
      default:   a = `AMPS_100K;
    endcase
    return a;
  endfunction

  trip_sel_t          ctrl_q;
  logic               overload_latch_q;
  logic               overtemp_error_q;
  logic [`CNT_W-1:0]  oc_cnt_q;
  logic [`CNT_W-1:0]  stuck_cnt_q [`PWM_N];
  logic [`PWM_N-1:0]  pwm_prev_q;
  wire logic [`PWM_N-1:0] pwm_stuck;
  wire logic [`PWM_N-1:0] pwm_edge;
  mode_t              mode_q;
  mode_t              mode_d;
  logic [31:0]        prdata_q;

  wire logic undervoltage_guard;
  wire logic overtemp_error;
  wire logic stuck_any;
  wire logic cause_any;
  wire logic overload_hit;

  // A supply below threshold is a cause only while it lasts.
  assign undervoltage_guard = !(gate_drive_supply_ok && vdd_supply_ok); // [R7] [R8] [R9]
  // The raw level joins the latch so the stage opens in the same cycle.
  assign overtemp_error = overtemp_error_q || (dev_reset_n && temp_error_level); // [R5]
  assign stuck_any      = |pwm_stuck; // [R14]
  assign cause_any      = overload_latch_q || overtemp_error
                          || undervoltage_guard || stuck_any; // [R22]

  // Stage drive: reset pin and every cause open the bridge at once.
  assign bridge_hiz       = !dev_reset_n || cause_any; // [R10] [R8] [R5] [R2]
  assign weak_pulldown_en = !dev_reset_n; // [R11]
  // Limiting, not shutdown, is the first answer to an overcurrent trip.
  assign current_limit    = overcurrent_trip && !bridge_hiz; // [R1]
  assign trip_level_resistor = ctrl_q; // [R3]

  // Flags pull low only; the reset pin keeps them released.
  assign shutdown_flag_n_o  = 1'b0;
  assign shutdown_flag_n_oe = dev_reset_n && cause_any; // [R17] [R19] [R22]
  assign temp_warning_n_o   = 1'b0;
  assign temp_warning_n_oe  = dev_reset_n && temp_warn_level; // [R4] [R19]

  // Overload timer: consecutive trip cycles while the stage is driving.
  assign overload_hit = overcurrent_trip && !bridge_hiz && (oc_cnt_q == OL_LIM - 1'b1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      oc_cnt_q <= '0;
    else if (ce)
      oc_cnt_q <= (overcurrent_trip && !bridge_hiz) ? oc_cnt_q + 1'b1 : '0;
  end

  // Overload latch: power-on reset and the reset pin clear it, so the
  // stage restarts only when the pin rises again.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overload_latch_q <= 1'b0; // [R7]
    else if (ce)
    begin
      if (!dev_reset_n)
        overload_latch_q <= 1'b0; // [R12] [R13]
      else if (overload_hit)
        overload_latch_q <= 1'b1; // [R2]
    end
  end

  // Overtemperature latch: survives until the reset pin goes low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overtemp_error_q <= 1'b0;
    else if (ce)
    begin
      if (!dev_reset_n)
        overtemp_error_q <= 1'b0; // [R6] [R12]
      else if (temp_error_level)
        overtemp_error_q <= 1'b1; // [R5]
    end
  end

  // One activity detector per PWM input. The stuck output is combinational
  // so an edge ends the shutdown in the same cycle it arrives.
  genvar gi;
  generate
    for (gi = 0; gi < `PWM_N; gi++)
    begin : g_act
      assign pwm_edge[gi]  = pwm_in[gi] != pwm_prev_q[gi];
      assign pwm_stuck[gi] = !pwm_edge[gi] && (stuck_cnt_q[gi] == STUCK_LIM); // [R16] [R15]

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          stuck_cnt_q[gi] <= '0;
        else if (ce)
        begin
          if (!dev_reset_n || pwm_edge[gi])
            stuck_cnt_q[gi] <= '0; // [R21] [R12]
          else if (stuck_cnt_q[gi] != STUCK_LIM)
            stuck_cnt_q[gi] <= stuck_cnt_q[gi] + 1'b1; // [R21]
        end
      end
    end
  endgenerate

  // Previous PWM levels. A reset value that differs from the pin only costs one
  // counter restart, since an edge never opens the stage by itself.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_prev_q <= '0;
    else if (ce)
      pwm_prev_q <= pwm_in;
  end

  // Mode shown in status, one cycle behind the pins.
  always_comb
  begin
    mode_d = MODE_RUN;
    if (!dev_reset_n)
      mode_d = MODE_HOLD;
    else if (cause_any)
      mode_d = MODE_OFF;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= MODE_HOLD;
    else if (ce)
      mode_q <= mode_d;
  end

  // APB decode: zero wait states, unmapped addresses and status writes error out.
  wire logic apb_acc   = psel && penable;
  wire logic hit_ctrl  = paddr == `OFS_CTRL;
  wire logic hit_stat  = paddr == `OFS_STATUS;
  wire logic hit_trip  = paddr == `OFS_TRIP;
  wire logic bad_acc   = !(hit_ctrl || ((hit_stat || hit_trip) && !pwrite));
  wire logic ctrl_we   = apb_acc && pwrite && hit_ctrl && ce;

  wire logic [31:0] status_word = {
    19'h0, mode_q,
    temp_warning_n_i, shutdown_flag_n_i, bridge_hiz, current_limit,
    temp_warn_level, pwm_stuck, undervoltage_guard, overtemp_error, overload_latch_q};

  wire logic [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_q}
                           : hit_stat ? status_word
                           : hit_trip ? {24'h0, trip_amps(ctrl_q)}
                           : 32'h0;

  // With the clock enable low the slave stalls, since no state may move.
  assign pready  = ce;
  assign pslverr = apb_acc && bad_acc;
  assign prdata  = prdata_q;

  // Read data is captured in the setup cycle so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (ce && psel && !penable && !pwrite)
      prdata_q <= rd_mux;
  end

  // Trip setting; codes past the last resistor step are kept and read as the lowest current.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= trip_sel_t'(`CTRL_RESET);
    else if (ctrl_we)
      ctrl_q <= trip_sel_t'(pwdata[`CTRL_SEL_LSB +: `CTRL_SEL_W]); // [R3]
  end

  // Checks next to the logic they guard.
  property p_limit_first;
    @(posedge pclk) disable iff (!presetn)
    overcurrent_trip && dev_reset_n && !cause_any |-> current_limit && !shutdown_flag_n_oe;
  endproperty
  a_limit_first: assert property (p_limit_first) else $error("no current limit"); // [R1]

  property p_overload;
    @(posedge pclk) disable iff (!presetn)
    ce && dev_reset_n && overload_hit ##1 dev_reset_n |-> overload_latch_q && bridge_hiz;
  endproperty
  a_overload: assert property (p_overload) else $error("overload not latched"); // [R2]

  property p_warn;
    @(posedge pclk) disable iff (!presetn)
    dev_reset_n && temp_warn_level && !cause_any |-> temp_warning_n_oe && !bridge_hiz;
  endproperty
  a_warn: assert property (p_warn) else $error("warning handling wrong"); // [R4]

  property p_ote_hold;
    @(posedge pclk) disable iff (!presetn)
    ce && dev_reset_n && temp_error_level ##1 dev_reset_n [*3]
      |-> overtemp_error_q && shutdown_flag_n_oe;
  endproperty
  a_ote_hold: assert property (p_ote_hold) else $error("overtemp latch lost"); // [R5] [R6]

  property p_uv;
    @(posedge pclk) disable iff (!presetn)
    undervoltage_guard |-> bridge_hiz && (shutdown_flag_n_oe == dev_reset_n);
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not acted on"); // [R8]

  property p_reset_pin;
    @(posedge pclk) disable iff (!presetn)
    ce && !dev_reset_n |=> !overload_latch_q && !overtemp_error_q
      && $past(bridge_hiz) && $past(weak_pulldown_en) && !$past(shutdown_flag_n_oe);
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored"); // [R12] [R19]

  property p_stuck;
    @(posedge pclk) disable iff (!presetn)
    dev_reset_n && ce && !pwm_edge[0] && stuck_cnt_q[0] == STUCK_LIM - 1'b1
      ##1 !pwm_edge[0] && dev_reset_n |-> bridge_hiz && shutdown_flag_n_oe;
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck input missed"); // [R14] [R17]

  property p_edge_clears;
    @(posedge pclk) disable iff (!presetn)
    pwm_edge[1] |-> !pwm_stuck[1];
  endproperty
  a_edge_clears: assert property (p_edge_clears) else $error("edge did not clear"); // [R15] [R16]

  property p_cause_hiz;
    @(posedge pclk) disable iff (!presetn)
    cause_any |-> bridge_hiz;
  endproperty
  a_cause_hiz: assert property (p_cause_hiz) else $error("cause without Hi-Z"); // [R22]

  property p_ote_latched;
    @(posedge pclk) disable iff (!presetn)
    overtemp_error_q && dev_reset_n |=> overtemp_error_q;
  endproperty
  a_ote_latched: assert property (p_ote_latched) else $error("overtemp cleared early"); // [R6]

  property p_ol_latched;
    @(posedge pclk) disable iff (!presetn)
    overload_latch_q && dev_reset_n |=> overload_latch_q;
  endproperty
  a_ol_latched: assert property (p_ol_latched) else $error("overload cleared early"); // [R13]

  property p_uv_release;
    @(posedge pclk) disable iff (!presetn)
    $fell(undervoltage_guard) && dev_reset_n && !overload_latch_q && !overtemp_error && !stuck_any
      |-> !bridge_hiz && !shutdown_flag_n_oe;
  endproperty
  a_uv_release: assert property (p_uv_release) else $error("no undervoltage recovery"); // [R9]

  property p_pin_low;
    @(posedge pclk) disable iff (!presetn)
    !dev_reset_n |-> weak_pulldown_en && bridge_hiz && !temp_warning_n_oe;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin low drive wrong"); // [R10] [R11] [R19]

  property p_cnt_restart;
    @(posedge pclk) disable iff (!presetn)
    ce && dev_reset_n && pwm_edge[1] |=> stuck_cnt_q[1] == '0;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart) else $error("stuck counter kept"); // [R21]

  property p_apb_err;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !hit_ctrl && !hit_stat && !hit_trip |-> pslverr;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped access accepted");

  c_overload: cover property (@(posedge pclk) disable iff (!presetn) $rose(overload_latch_q));
  c_overtemp: cover property (@(posedge pclk) disable iff (!presetn) $rose(overtemp_error_q));
  c_stuck:    cover property (@(posedge pclk) disable iff (!presetn) $rose(stuck_any));
  c_uv:       cover property (@(posedge pclk) disable iff (!presetn) $rose(undervoltage_guard));
  c_restart:  cover property (@(posedge pclk) disable iff (!presetn)
                              $rose(dev_reset_n) ##1 !bridge_hiz);

endmodule

`default_nettype wire

/* pwm_partner.sv */
// Model of the PWM modulator that feeds the supervisor's two PWM inputs.
// Assumes it shares pclk and presetn with the supervisor.
`timescale 1ns/1ps
`default_nettype none

module pwm_partner (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control from the bench.
  input  wire logic       run,
  input  wire logic [2:0] duty,
  // Complementary bridge PWM pair.
  output logic [1:0]      pwm
);
  logic [2:0] cnt_q;
  logic       hi_w;

  // At most seven of eight slots high keeps the index at 87.5 percent, under the limit.
  assign hi_w = (cnt_q < ((duty == 3'h0) ? 3'h1 : duty));

  // A stopped modulator freezes both lines; that is the stuck fault the bench asks for.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 3'h0;
      pwm   <= 2'b01;
    end
    else if (run)
    begin
      cnt_q <= cnt_q + 3'h1;
      pwm   <= {!hi_w, hi_w};
    end
  end
endmodule

`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the amplifier stage fault supervisor.
// Assumes the defines header, the package, the design and pwm_partner are compiled first.
`timescale 1ns/1ps
`include "amp_fault_defines.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_top;
  import amp_fault_pkg::*;
  // Bench signals.
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        dev_reset_n, gd_ok, vdd_ok, oc_trip, t_warn, t_err, run;
  logic        bridge_hiz, current_limit, weak_pulldown_en, sd_oe, sd_o, tw_oe, tw_o;
  logic [1:0]  pwm;
  logic [2:0]  duty;
  trip_sel_t   trip_sel;
  int          n_errors, n_checks, cyc;
  int          amps[8] = '{16, 13, 8, 5, 4, 4, 4, 4};
  // Model state: overload, overtemp, undervoltage and stuck causes.
  logic        ol, ot, uv, st;
  // Both flags are open drain with pull-ups, so a released pin reads high.
  wire logic   sd_pin = (sd_oe && !sd_o) ? 1'b0 : 1'b1;
  wire logic   tw_pin = (tw_oe && !tw_o) ? 1'b0 : 1'b1;

  amp_stage_fault_supervisor dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_reset_n(dev_reset_n), .gate_drive_supply_ok(gd_ok),
    .vdd_supply_ok(vdd_ok), .overcurrent_trip(oc_trip), .temp_warn_level(t_warn),
    .temp_error_level(t_err), .pwm_in(pwm), .bridge_hiz(bridge_hiz),
    .current_limit(current_limit), .weak_pulldown_en(weak_pulldown_en),
    .trip_level_resistor(trip_sel), .shutdown_flag_n_i(sd_pin), .shutdown_flag_n_o(sd_o),
    .shutdown_flag_n_oe(sd_oe), .temp_warning_n_i(tw_pin), .temp_warning_n_o(tw_o),
    .temp_warning_n_oe(tw_oe));

  pwm_partner far (.pclk(pclk), .presetn(presetn), .run(run), .duty(duty), .pwm(pwm));

  // Clock at 4 ns period.
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = !pclk;
  end

  // Hang guard; the whole run needs well under six thousand cycles.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compare the power stage outputs with the model.
  task automatic chk_outs();
    logic c;
    c = ol | ot | uv | st;
    `CHK("hiz", !dev_reset_n | c, bridge_hiz)
    `CHK("sd_oe", dev_reset_n & c, sd_oe)
    `CHK("warn_oe", dev_reset_n & t_warn, tw_oe)
    `CHK("climit", oc_trip & dev_reset_n & !c, current_limit)
    `CHK("pulldown", !dev_reset_n, weak_pulldown_en)
  endtask

  // Outputs are looked at 1 ns after an edge; the task returns on an edge so
  // the next stimulus lands there by non-blocking assignment.
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
    chk_outs();
    @(posedge pclk);
  endtask

  initial
  begin
    void'($urandom(32'h3cc8));
    {presetn, psel, penable, pwrite, paddr, pwdata, dev_reset_n} = '0;
    {oc_trip, t_warn, t_err, ol, ot, uv, st} = '0;
    {ce, gd_ok, vdd_ok, run} = 4'hf;
    duty = 3'($urandom_range(7, 1));
    repeat (4) @(posedge pclk);
    presetn     <= 1'b1;
    dev_reset_n <= 1'b1;
    tick(2);
    apb(1'b0, `OFS_CTRL, 32'h0);
    `CHK("ctrl_reset", 32'h0, r)
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, `OFS_CTRL, ($urandom() & 32'hffff_fff8) | i);
      apb(1'b0, `OFS_TRIP, 32'h0);
      `CHK("trip_sel", 3'(i), trip_sel)
      `CHK("trip_amps", 32'(amps[i]), r)
    end
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("err_unmapped", 1'b1, e)
    apb(1'b1, `OFS_STATUS, 32'hffff_ffff);
    `CHK("err_readonly", 1'b1, e)
    // Warning alone must not shut the stage down.
    @(posedge pclk);
    t_warn <= 1'b1;
    tick(1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("status_low", 8'h20, r[7:0])
    // Error level latches until the reset pin is pulsed; both flags stay low until the pulse.
    t_err <= 1'b1;
    ot = 1'b1;
    tick(1);
    t_err <= 1'b0;
    tick(3);
    dev_reset_n <= 1'b0;
    tick(2);
    ot = 1'b0;
    t_warn <= 1'b0;
    dev_reset_n <= 1'b1;
    tick(1);
    // Each supply alone shuts down and recovers without a latch.
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        gd_ok <= 1'b0;
      else
        vdd_ok <= 1'b0;
      uv = 1'b1;
      tick(1);
      {gd_ok, vdd_ok} <= 2'b11;
      uv = 1'b0;
      tick(1);
    end
    // Overload: limit first, latch later; cleared by pin edge, then by power-on reset.
    for (int k = 0; k < 2; k++)
    begin
      oc_trip <= 1'b1;
      tick(240);
      ol = 1'b1;
      tick(20);
      oc_trip <= 1'b0;
      tick(100);
      // Power-on reset clears the overload latch at once; the pin clears it at the next clock edge.
      if (k == 0)
        dev_reset_n <= 1'b0;
      else
      begin
        presetn <= 1'b0;
        ol = 1'b0;
      end
      tick(2);
      ol = 1'b0;
      {presetn, dev_reset_n} <= 2'b11;
      tick(1);
    end
    // Stuck inputs shut down after the timeout and recover on renewed switching.
    run <= 1'b0;
    tick(2400);
    st = 1'b1;
    tick(200);
    `CHK("sd_pin", 1'b0, sd_pin)
    // Both channels stuck, stage open, shutdown pin low, warning pin high, mode off.
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("status_stuck", 32'h0000_1298, r)
    duty <= 3'($urandom_range(7, 1));
    run  <= 1'b1;
    st = 1'b0;
    // Up to seven partner cycles may pass before its next level change.
    tick(9);
    wrap_up();
  end
endmodule

`default_nettype wire
